// *** logic/srt_ctrl.sv ***
// string repeat and soft trap control with avalon register slave
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module srt_ctrl
    import srt_pkg::*;
#(
    parameter int LIM_DEPTH = 8
)(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic irq_pending,
    output logic trap_valid,
    output logic [7:0] trap_vector,
    output logic dst_seg_is_extra
);
    localparam int LAW = $clog2(LIM_DEPTH);

    // ------------------------------------------------------------
    // architectural state
    // ------------------------------------------------------------
    logic [31:0] loop_count_register;
    logic [31:0] source_index_register;
    logic [31:0] destination_index_register;
    logic [31:0] instruction_pointer;
    logic [31:0] ret_ip;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] cmd;
    logic zero_flag;
    logic direction_flag;
    logic overflow_flag;
    logic busy;
    logic bnd_wait;
    logic icpt;
    logic trap;
    logic [7:0] vec;
    logic rd_ack;
    logic [31:0] rdata;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire logic [3:0] op_raw = cmd[SRT_CMD_OP_LSB +: 4];
    wire logic [1:0] sz = cmd[SRT_CMD_SIZE_LSB +: 2];
    wire logic [1:0] pfx = cmd[SRT_CMD_PFX_LSB +: 2];
    wire logic reg_lim = cmd[SRT_CMD_REGLIM_BIT];
    wire logic [31:0] ilen = {28'h0, cmd[SRT_CMD_LEN_LSB +: 4]};
    wire logic [LAW-1:0] lim_addr = cmd[SRT_CMD_ADDR_LSB +: LAW];
    wire logic is_str = (op_raw >= SRT_OP_MOVE_STRING_INSTR) && (op_raw <= SRT_OP_STORE_STRING_INSTR);
    wire logic is_cmp = (op_raw == SRT_OP_COMPARE_STRING_INSTR) || (op_raw == SRT_OP_SCAN_STRING_INSTR);

    // bus decode; writes never wait, waitrequest drops for one cycle per read
    wire logic acc = avs_read | avs_write;
    wire logic wr_hit = avs_write & ~avs_waitrequest;
    wire logic wr_cmd = wr_hit & (avs_address == SRT_REG_CMD) & ~busy;
    wire logic wr_lim = wr_hit & (avs_address == SRT_REG_LIM);
    assign avs_waitrequest = acc & ~rd_ack & ~avs_write;

    // ------------------------------------------------------------
    // element compare and index stepping
    // ------------------------------------------------------------
    wire logic [31:0] sz_mask = (sz == SRT_SZ_BYTE) ? 32'h0000_00FF :
                                (sz == SRT_SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    wire logic elem_eq = ((opa ^ opb) & sz_mask) == 32'h0;
    wire logic [31:0] cnt_dec = loop_count_register - SRT_ONE;
    wire logic [31:0] next_src;
    wire logic [31:0] next_dst;

    srt_step u_step_src (
        .idx(source_index_register),
        .size(sz),
        .dir(direction_flag),
        .idx_next(next_src)
    );

    srt_step u_step_dst (
        .idx(destination_index_register),
        .size(sz),
        .dir(direction_flag),
        .idx_next(next_dst)
    );

    // zero flag after this element, updated before the termination test
    wire logic next_zf = is_cmp ? elem_eq : zero_flag;
    wire logic stop_cnt = (pfx == SRT_PFX_NONE) || (cnt_dec == 32'h0);
    wire logic stop_zf = is_cmp && (((pfx == SRT_PFX_REPE) && !next_zf) ||
                                    ((pfx == SRT_PFX_REPNE) && next_zf));
    wire logic str_done = stop_cnt | stop_zf;
    wire logic str_go = busy & is_str & ~bnd_wait;
    // zero count with a prefix performs no element, except scan and compare, which wrap
    wire logic str_skip = !is_cmp && (pfx != SRT_PFX_NONE) && (loop_count_register == 32'h0);
    wire logic str_icpt = str_go & irq_pending & ~str_done & ~str_skip;

    // ------------------------------------------------------------
    // range check using limit memory
    // ------------------------------------------------------------
    wire logic [31:0] lim_lo;
    wire logic [31:0] lim_hi;

    srt_limit_mem #(.DEPTH(LIM_DEPTH), .AW(LAW)) u_lim (
        .clk(clk),
        .wr_en(wr_lim),
        .wr_addr(avs_writedata[SRT_CMD_ADDR_LSB +: LAW]),
        .wr_data({8'h0, avs_writedata[23:0]}),
        .rd_addr(lim_addr),
        .rd_lo(lim_lo),
        .rd_hi(lim_hi)
    );

    wire logic out_rng = ($signed(opa) < $signed(lim_lo)) ||
                         ($signed(opa) > $signed(lim_hi));

    // ------------------------------------------------------------
    // execution sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy <= 1'b0;
            bnd_wait <= 1'b0;
            cmd <= 32'h0;
            trap <= 1'b0;
            vec <= 8'h0;
            icpt <= 1'b0;
            trap_valid <= 1'b0;
            instruction_pointer <= 32'h0;
            ret_ip <= 32'h0;
            loop_count_register <= 32'h0;
            source_index_register <= 32'h0;
            destination_index_register <= 32'h0;
            opa <= 32'h0;
            opb <= 32'h0;
            zero_flag <= 1'b0;
            direction_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end
        else
        begin
            trap_valid <= 1'b0;
            if (wr_cmd)
            begin
                cmd <= avs_writedata;
                busy <= 1'b1;
                bnd_wait <= (avs_writedata[SRT_CMD_OP_LSB +: 4] == SRT_OP_BOUND);
                icpt <= 1'b0;
            end
            else if (wr_hit && !busy)
            begin
                // architectural registers writable while idle
                unique case (avs_address)
                    SRT_REG_COUNT: loop_count_register <= avs_writedata;
                    SRT_REG_SRC: source_index_register <= avs_writedata;
                    SRT_REG_DST: destination_index_register <= avs_writedata;
                    SRT_REG_IP: instruction_pointer <= avs_writedata;
                    SRT_REG_OPA: opa <= avs_writedata;
                    SRT_REG_OPB: opb <= avs_writedata;
                    SRT_REG_FLAGS:
                    begin
                        zero_flag <= avs_writedata[SRT_FLG_ZF];
                        direction_flag <= avs_writedata[SRT_FLG_DF];
                        overflow_flag <= avs_writedata[SRT_FLG_OF];
                    end
                    default: ;
                endcase
            end
            else if (busy && bnd_wait)
                bnd_wait <= 1'b0; // limit memory read data now valid
            else if (busy && is_str)
            begin
                if (str_skip)
                begin
                    busy <= 1'b0;
                    instruction_pointer <= instruction_pointer + ilen;
                end
                else
                begin
                    source_index_register <= next_src;
                    destination_index_register <= next_dst;
                    zero_flag <= next_zf;
                    if (pfx != SRT_PFX_NONE)
                        loop_count_register <= cnt_dec;
                    if (str_done)
                    begin
                        busy <= 1'b0;
                        instruction_pointer <= instruction_pointer + ilen;
                    end
                    else if (irq_pending)
                    begin
                        // pointer stays on the string instruction for restart
                        busy <= 1'b0;
                        icpt <= 1'b1;
                    end
                end
            end
            else if (busy)
            begin
                busy <= 1'b0;
                instruction_pointer <= instruction_pointer + ilen;
                unique case (op_raw)
                    SRT_OP_JCZ:
                        if (loop_count_register == 32'h0)
                            instruction_pointer <= opa;
                    SRT_OP_INT:
                    begin
                        trap <= 1'b1;
                        trap_valid <= 1'b1;
                        vec <= cmd[SRT_CMD_VEC_LSB +: 8];
                        ret_ip <= instruction_pointer + ilen;
                    end
                    SRT_OP_INTO:
                        if (overflow_flag)
                        begin
                            trap <= 1'b1;
                            trap_valid <= 1'b1;
                            vec <= SRT_VEC_OVF;
                            ret_ip <= instruction_pointer + ilen;
                        end
                    SRT_OP_BOUND:
                        if (reg_lim || out_rng)
                        begin
                            trap <= 1'b1;
                            trap_valid <= 1'b1;
                            vec <= reg_lim ? SRT_VEC_UD : SRT_VEC_BOUND;
                            instruction_pointer <= instruction_pointer;
                            ret_ip <= instruction_pointer;
                        end
                    SRT_OP_STD: direction_flag <= 1'b1;
                    SRT_OP_CLD: direction_flag <= 1'b0;
                    SRT_OP_INTERRUPT_RETURN_INSTR:
                    begin
                        trap <= 1'b0;
                        instruction_pointer <= ret_ip;
                    end
                    default: ;
                endcase
            end
        end
    end

    // destination accesses never take a segment override
    assign dst_seg_is_extra = 1'b1;
    assign trap_vector = vec;

    // ------------------------------------------------------------
    // read path: one registered wait state per read
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (avs_address)
            SRT_REG_CMD: rdata = cmd;
            SRT_REG_COUNT: rdata = loop_count_register;
            SRT_REG_SRC: rdata = source_index_register;
            SRT_REG_DST: rdata = destination_index_register;
            SRT_REG_IP: rdata = instruction_pointer;
            SRT_REG_FLAGS: rdata = {29'h0, overflow_flag, direction_flag, zero_flag};
            SRT_REG_OPA: rdata = opa;
            SRT_REG_OPB: rdata = opb;
            SRT_REG_STAT: rdata = {16'h0, vec, 5'h0, icpt, trap, busy};
            default: rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_ack <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else
        begin
            rd_ack <= avs_read & ~rd_ack;
            if (avs_read && !rd_ack)
                avs_readdata <= rdata;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_str_step;
        str_go && !str_skip && pfx != SRT_PFX_NONE;
    endsequence

    chk_jcz_taken: assert property (@(posedge clk) disable iff (!arst_n)
        busy && !bnd_wait && op_raw == SRT_OP_JCZ && loop_count_register == 32'h0
        |=> instruction_pointer == $past(opa))
        else $error("count-zero jump not taken");
    chk_count_dec: assert property (@(posedge clk) disable iff (!arst_n)
        s_str_step |=> loop_count_register == $past(loop_count_register) - SRT_ONE)
        else $error("count not decremented");
    chk_int_vector: assert property (@(posedge clk) disable iff (!arst_n)
        busy && op_raw == SRT_OP_INT
        |=> trap_valid && trap_vector == $past(cmd[SRT_CMD_VEC_LSB +: 8]))
        else $error("software interrupt vector wrong");
    chk_into_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        busy && op_raw == SRT_OP_INTO && !overflow_flag |=> !trap_valid)
        else $error("overflow trap without overflow");
    chk_bound_trap: assert property (@(posedge clk) disable iff (!arst_n)
        busy && !bnd_wait && op_raw == SRT_OP_BOUND && !reg_lim && out_rng
        |=> trap_valid && trap_vector == SRT_VEC_BOUND)
        else $error("bound violation missed");
    chk_bound_ud: assert property (@(posedge clk) disable iff (!arst_n)
        busy && !bnd_wait && op_raw == SRT_OP_BOUND && reg_lim |=> trap_vector == SRT_VEC_UD)
        else $error("register limit not invalid opcode");
    chk_single_elem: assert property (@(posedge clk) disable iff (!arst_n)
        str_go && pfx == SRT_PFX_NONE |=> !busy)
        else $error("unprefixed string ran more than once");
    chk_dir_step: assert property (@(posedge clk) disable iff (!arst_n)
        str_go && !str_skip && direction_flag
        |=> source_index_register < $past(source_index_register) ||
            $past(source_index_register) < 32'h0000_0004)
        else $error("index not decremented");
    chk_icpt_ip: assert property (@(posedge clk) disable iff (!arst_n)
        str_icpt |=> instruction_pointer == $past(instruction_pointer) && icpt && !busy)
        else $error("interrupted string pointer moved");
    chk_repe_stop: assert property (@(posedge clk) disable iff (!arst_n)
        str_go && !str_skip && is_cmp && pfx == SRT_PFX_REPE && !elem_eq |=> !busy)
        else $error("equal prefix failed to stop");
endmodule : srt_ctrl
`default_nettype wire

// *** logic/srt_pkg.sv ***
// package: shared constants and types for the string repeat and soft trap control block
package srt_pkg;
    // ------------------------------------------------------------
    // avalon register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [5:0] SRT_REG_CMD = 6'h00;    // write: command, read: last command
    localparam logic [5:0] SRT_REG_COUNT = 6'h04;  // loop count register
    localparam logic [5:0] SRT_REG_SRC = 6'h08;    // source index register
    localparam logic [5:0] SRT_REG_DST = 6'h0C;    // destination index register
    localparam logic [5:0] SRT_REG_IP = 6'h10;     // instruction pointer
    localparam logic [5:0] SRT_REG_FLAGS = 6'h14;  // flags
    localparam logic [5:0] SRT_REG_OPA = 6'h18;    // operand a / tested value / target
    localparam logic [5:0] SRT_REG_OPB = 6'h1C;    // operand b (element compare data)
    localparam logic [5:0] SRT_REG_STAT = 6'h20;   // status (read only)
    localparam logic [5:0] SRT_REG_LIM = 6'h24;    // limit memory write port

    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int SRT_CMD_OP_LSB = 0;     // 4-bit opcode
    localparam int SRT_CMD_SIZE_LSB = 4;   // 2-bit element size code
    localparam int SRT_CMD_PFX_LSB = 6;    // 2-bit repeat prefix
    localparam int SRT_CMD_REGLIM_BIT = 8; // limit operand encoded as register
    localparam int SRT_CMD_LEN_LSB = 9;    // 4-bit instruction length
    localparam int SRT_CMD_VEC_LSB = 16;   // 8-bit vector number
    localparam int SRT_CMD_ADDR_LSB = 24;  // 3-bit limit memory word index

    // flag bit positions
    localparam int SRT_FLG_ZF = 0;
    localparam int SRT_FLG_DF = 1;
    localparam int SRT_FLG_OF = 2;

    // status bit positions
    localparam int SRT_ST_BUSY = 0;
    localparam int SRT_ST_TRAP = 1;
    localparam int SRT_ST_ICPT = 2;  // last command was a string run that was interrupted
    localparam int SRT_ST_VEC_LSB = 8;

    // fixed exception vectors
    localparam logic [7:0] SRT_VEC_BOUND = 8'h05;
    localparam logic [7:0] SRT_VEC_OVF = 8'h04;
    localparam logic [7:0] SRT_VEC_UD = 8'h06;

    localparam logic [31:0] SRT_ONE = 32'h0000_0001;

    typedef enum logic [3:0] {
        SRT_OP_NOP, SRT_OP_JCZ, SRT_OP_INT, SRT_OP_INTO, SRT_OP_BOUND, SRT_OP_STD,
        SRT_OP_CLD, SRT_OP_MOVE_STRING_INSTR, SRT_OP_COMPARE_STRING_INSTR, SRT_OP_SCAN_STRING_INSTR, SRT_OP_LOAD_STRING_INSTR, SRT_OP_STORE_STRING_INSTR,
        SRT_OP_INTERRUPT_RETURN_INSTR
    } srt_op_t;

    typedef enum logic [1:0] {SRT_PFX_NONE, SRT_PFX_REP, SRT_PFX_REPE, SRT_PFX_REPNE} srt_pfx_t;

    typedef enum logic [1:0] {SRT_SZ_BYTE, SRT_SZ_WORD, SRT_SZ_DWORD, SRT_SZ_RSVD} srt_sz_t;
endpackage : srt_pkg

// *** logic/srt_limit_mem.sv ***
// limit memory: small word store holding bound limit pairs, registered read
`timescale 1ns/1ps
`default_nettype none
module srt_limit_mem
    import srt_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW = 3
)(
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [31:0] rd_lo,
    output logic [31:0] rd_hi
);
    logic [31:0] mem [DEPTH];
    wire logic [AW-1:0] hi_addr = rd_addr + AW'(1);

    // ------------------------------------------------------------
    // storage; no reset so it maps onto plain ram
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_lo <= mem[rd_addr];   // lower address holds lower limit
        rd_hi <= mem[hi_addr];   // next word holds upper limit
    end
endmodule : srt_limit_mem
`default_nettype wire

// *** logic/srt_step.sv ***
// index stepper: adjusts an index by the element size in the flagged direction
`timescale 1ns/1ps
`default_nettype none
module srt_step
    import srt_pkg::*;
(
    input wire logic [31:0] idx,
    input wire logic [1:0] size,
    input wire logic dir,
    output logic [31:0] idx_next
);
    // byte=1, word=2, dword=4 bytes per element
    wire logic [31:0] step = (size == SRT_SZ_DWORD) ? 32'h0000_0004 :
                             (size == SRT_SZ_WORD) ? 32'h0000_0002 : SRT_ONE;
    // clear direction counts up, set direction counts down
    assign idx_next = dir ? idx - step : idx + step;
endmodule : srt_step
`default_nettype wire

// *** testbench/tb_top.sv ***
// testbench: register-level scenarios for the string repeat and soft trap block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import srt_pkg::*;
;
logic clk, arst_n, avs_read, avs_write, irq_pending, trap_valid, avs_waitrequest, dst_seg_is_extra;
logic [5:0] avs_address;
logic [31:0] avs_writedata, avs_readdata, rv, c;
logic [3:0] avs_byteenable;
logic [7:0] trap_vector;
int bad_count, num_checks, trap_cnt, k;
// bound cases: tested value and whether a trap is due (limits 10 and 20)
logic [31:0] bv [5] = '{32'h9, 32'hA, 32'h14, 32'h15, 32'hFFFF_FFFF};
logic bt [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
// repeat cases: prefix, elements equal, count left
logic [1:0] rp [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
logic re [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
logic [31:0] rc [5] = '{32'h0, 32'h0, 32'h3, 32'h3, 32'h0};

srt_ctrl i_srt_ctrl (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_pending, .trap_valid,
    .trap_vector, .dst_seg_is_extra);

// ----------------------------------------
// clock and trap pulse counter
// ----------------------------------------
initial
begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
end
// pulse is one cycle wide, so each pulse is counted at one edge only
always @(posedge clk)
begin
    if (trap_valid === 1'b1)
        trap_cnt++;
end

// ----------------------------------------
// bus and check helpers
// ----------------------------------------
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        bad_count++;
        $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
endtask : chk
// request held until waitrequest is seen low; an idle edge follows the release
task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= ~we;
    do
        @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
endtask : bus
task automatic w(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
endtask : w
task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
endtask : rdchk
// command with length 2 and limit index 0; the other fields come from the arguments
function automatic logic [31:0] mk(input logic [3:0] op, input logic [1:0] sz,
    input logic [1:0] pf, input logic [7:0] v, input logic rl);
    return {8'h00, v, 3'h0, 4'h2, rl, pf, sz, op};
endfunction : mk
// polls status without issuing a command, so no state is disturbed
task automatic wait_idle;
    do
        bus(1'b0, SRT_REG_STAT, 32'h0);
    while (rv[SRT_ST_BUSY] !== 1'b0);
endtask : wait_idle
task automatic run(input logic [31:0] cmd);
    w(SRT_REG_CMD, cmd);
    wait_idle;
endtask : run

// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_jump;
    w(SRT_REG_IP, 32'h100);
    w(SRT_REG_OPA, 32'h800);
    w(SRT_REG_COUNT, 32'h1);
    run(mk(4'h1, 2'h0, 2'h0, 8'h00, 1'b0));
    rdchk(SRT_REG_IP, 32'h102);
    w(SRT_REG_COUNT, 32'h0);
    run(mk(4'h1, 2'h0, 2'h0, 8'h00, 1'b0));
    rdchk(SRT_REG_IP, 32'h800);
    $display("jump test done");
endtask : t_jump
task automatic t_traps;
    for (int i = 0; i < 2; i++)
    begin
        w(SRT_REG_IP, 32'h200);
        k = trap_cnt;
        run(mk(4'h2, 2'h0, 2'h0, i ? 8'hFF : 8'h00, 1'b0));
        chk(32'(trap_cnt - k), 32'h1);
        chk({24'h0, trap_vector}, i ? 32'hFF : 32'h0);
        w(SRT_REG_IP, 32'h700);
        run(mk(4'hC, 2'h0, 2'h0, 8'h00, 1'b0));
        rdchk(SRT_REG_IP, 32'h202);
        w(SRT_REG_FLAGS, 32'(i) << SRT_FLG_OF);
        k = trap_cnt;
        run(mk(4'h3, 2'h0, 2'h0, 8'h00, 1'b0));
        chk(32'(trap_cnt - k), 32'(i));
    end
    chk({24'h0, trap_vector}, {24'h0, SRT_VEC_OVF});
    $display("trap test done");
endtask : t_traps
task automatic t_bound;
    w(SRT_REG_LIM, 32'h0000_000A);
    w(SRT_REG_LIM, 32'h0100_0014);
    for (int i = 0; i < 5; i++)
    begin
        w(SRT_REG_OPA, bv[i]);
        k = trap_cnt;
        run(mk(4'h4, 2'h2, 2'h0, 8'h00, 1'b0));
        chk(32'(trap_cnt - k), {31'h0, bt[i]});
    end
    chk({24'h0, trap_vector}, {24'h0, SRT_VEC_BOUND});
    run(mk(4'h4, 2'h2, 2'h0, 8'h00, 1'b1));
    chk({24'h0, trap_vector}, {24'h0, SRT_VEC_UD});
    $display("bound test done");
endtask : t_bound
// first pass decrements, second increments, over all three element sizes
task automatic t_step;
    for (int d = 0; d < 2; d++)
    begin
        run(mk(d ? 4'h6 : 4'h5, 2'h0, 2'h0, 8'h00, 1'b0));
        bus(1'b0, SRT_REG_FLAGS, 32'h0);
        chk({31'h0, rv[SRT_FLG_DF]}, 32'(1 - d));
        for (int s = 0; s < 3; s++)
        begin
            w(SRT_REG_COUNT, 32'h5);
            w(SRT_REG_SRC, 32'h1000);
            w(SRT_REG_DST, 32'h2000);
            run(mk(4'h7, 2'(s), 2'h0, 8'h00, 1'b0));
            c = d ? (SRT_ONE << s) : -(SRT_ONE << s);
            rdchk(SRT_REG_SRC, 32'h1000 + c);
            rdchk(SRT_REG_DST, 32'h2000 + c);
            rdchk(SRT_REG_COUNT, 32'h5);
        end
    end
    $display("step test done");
endtask : t_step
// zero flag preset opposite to the compare result; upper bits always differ, low byte equal only in the equal cases
task automatic t_rep;
    for (int i = 0; i < 5; i++)
    begin
        w(SRT_REG_COUNT, 32'h4);
        w(SRT_REG_SRC, 32'h0);
        w(SRT_REG_OPA, 32'h155);
        w(SRT_REG_OPB, re[i] ? 32'h255 : 32'h256);
        w(SRT_REG_FLAGS, {31'h0, ~re[i]});
        run(mk(i[0] ? 4'h9 : 4'h8, 2'h0, rp[i], 8'h00, 1'b0));
        rdchk(SRT_REG_COUNT, rc[i]);
        rdchk(SRT_REG_SRC, 32'h4 - rc[i]);
        bus(1'b0, SRT_REG_FLAGS, 32'h0);
        chk({31'h0, rv[SRT_FLG_ZF]}, {31'h0, re[i]});
    end
    // zero count on a compare wraps before the test; unequal bytes stop it at once
    w(SRT_REG_COUNT, 32'h0);
    run(mk(4'h8, 2'h0, 2'h2, 8'h00, 1'b0));
    rdchk(SRT_REG_COUNT, 32'hFFFF_FFFF);
    $display("repeat test done");
endtask : t_rep
// interrupt lands mid-string, then the same command restarts the remainder
task automatic t_irq;
    w(SRT_REG_COUNT, 32'h8);
    w(SRT_REG_SRC, 32'h40);
    w(SRT_REG_IP, 32'h300);
    w(SRT_REG_CMD, mk(4'h7, 2'h0, 2'h1, 8'h00, 1'b0));
    irq_pending <= 1'b1;
    wait_idle;
    chk({31'h0, rv[SRT_ST_ICPT]}, 32'h1);
    bus(1'b0, SRT_REG_COUNT, 32'h0);
    c = rv;
    chk({31'h0, c != 0}, 32'h1);
    rdchk(SRT_REG_SRC, 32'h48 - c);
    rdchk(SRT_REG_IP, 32'h300);
    irq_pending <= 1'b0;
    run(mk(4'h7, 2'h0, 2'h1, 8'h00, 1'b0));
    rdchk(SRT_REG_COUNT, 32'h0);
    rdchk(SRT_REG_SRC, 32'h48);
    $display("interrupt test done");
endtask : t_irq

// ----------------------------------------
// sequence, watchdog and verdict
// ----------------------------------------
task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask : wrap_up
initial
begin
    arst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    irq_pending = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, dst_seg_is_extra}, 32'h1);
    rdchk(6'h3C, 32'h0);
    t_jump;
    t_traps;
    t_bound;
    t_step;
    t_rep;
    t_irq;
    wrap_up;
end
// about 20000 cycles, well above the few hundred the scenarios take
initial
begin
    #500000;
    bad_count++;
    wrap_up;
end
endmodule : tb_top
`default_nettype wire
